// File: cmb_pkg.sv
// Shared constants for the CAN message buffer control block
package cmb_pkg;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned NUM_TX      = 8;
  localparam int unsigned NUM_BUF     = 32;
  localparam int unsigned BUF_WORDS   = 8;
  // Register byte offsets
  localparam logic [11:0] OFS_CTL0    = 12'h000;
  localparam logic [11:0] OFS_IRQ_ST  = 12'h010;
  localparam logic [11:0] OFS_IRQ_EN  = 12'h014;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h018;
  localparam logic [11:0] OFS_ENGINE  = 12'h01C;
  localparam logic [11:0] OFS_BUF     = 12'h800;
  // Word index inside one message buffer
  localparam logic [2:0]  W_SID       = 3'h0;
  localparam logic [2:0]  W_EID       = 3'h1;
  localparam logic [2:0]  W_LEN       = 3'h2;
  localparam logic [2:0]  W_DATA0     = 3'h3;
  localparam logic [2:0]  W_STAT      = 3'h7;
  // Implemented bits of each buffer word
  localparam logic [15:0] MASK_SID    = 16'h1FFF;
  localparam logic [15:0] MASK_EID    = 16'h0FFF;
  localparam logic [15:0] MASK_LEN    = 16'hFF1F;
  localparam logic [15:0] MASK_DATA   = 16'hFFFF;
  localparam logic [15:0] MASK_STAT   = 16'h1F00;
  // Field positions
  localparam int unsigned CTL_DIR     = 7;
  localparam int unsigned CTL_ABT     = 6;
  localparam int unsigned CTL_LARB    = 5;
  localparam int unsigned CTL_ERR     = 4;
  localparam int unsigned CTL_REQ     = 3;
  localparam int unsigned CTL_RTR     = 2;
  localparam int unsigned SID_IDE     = 0;
  localparam int unsigned STAT_FILT   = 8;
  localparam logic [7:0]  CTL_SW_MASK = 8'h8F;
  localparam logic [7:0]  CTL_FLAGS   = 8'h70;
  // Interrupt event bits
  localparam int unsigned EV_TX_OK    = 0;
  localparam int unsigned EV_ABORT    = 1;
  localparam int unsigned EV_LOST     = 2;
  localparam int unsigned EV_ERR      = 3;
  localparam int unsigned EV_RX       = 4;
  localparam int unsigned NUM_EV      = 5;
  // Reset values
  localparam logic [7:0]  CTL_RESET   = 8'h00;
  localparam logic [4:0]  IRQ_RESET   = 5'h00;
  // Decode results
  localparam logic [2:0]  DEC_NONE    = 3'h0;
  localparam logic [2:0]  DEC_CTL     = 3'h1;
  localparam logic [2:0]  DEC_IRQ_ST  = 3'h2;
  localparam logic [2:0]  DEC_IRQ_EN  = 3'h3;
  localparam logic [2:0]  DEC_IRQ_CLR = 3'h4;
  localparam logic [2:0]  DEC_ENGINE  = 3'h5;
  localparam logic [2:0]  DEC_BUF     = 3'h6;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    CMB_TX_IDLE = 1'b0,
    CMB_TX_BUSY = 1'b1
  } cmb_tx_e;
endpackage : cmb_pkg

// File: cmb_buffer_ctrl.sv
// CAN message buffer control: AXI4-Lite registers, buffer RAM, transmit arbitration
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// R1: Direction bit 7 of a control byte set means transmit buffer, clear means receive.
// R2: Aborted flag sets when a queued message is aborted, stays clear on success.
// R3: Lost-arbitration flag sets when the engine reports lost arbitration for the buffer.
// R4: Transmit-error flag sets when the engine reports a bus error for the buffer.
// R5: Writing 1 to send request queues; hardware clears it after successful transmission.
// R6: Writing 0 to a set send request asks for abort of that transmission.
// R7: Remote frame with auto-answer enabled sets send request; otherwise request unchanged.
// R8: Two-bit priority per buffer, 11 highest down to 00 lowest.
// R9: Aborted, lost and error flags clear whenever send request becomes set.
// R10: Each control word serves two buffers: low byte even, high byte odd.
// R11: First word holds 11-bit identifier in bits 12-2, substitute remote flag bit 1.
// R12: Bit 0 of first word selects extended identifier on transmit.
// R13: Extended identifier bits 17..6 in word two, bits 5..0 in word three 15-10.
// R14: Software writes both reserved frame bits of the length word as zero.
// R15: Length word carries data length code in bits 3-0, remote flag bit 9.
// R16: Eight data bytes per buffer, two per word, low byte first.
// R17: Receive writes matching filter number into status bits 12-8, never transmit buffers.
// R18: Pending transmit buffer of highest priority starts first; ties go to higher number.
module cmb_buffer_ctrl (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             tx_valid,
  output logic [2:0]       tx_buf,
  output logic             tx_extended,
  output logic [15:0]      tx_id_word,
  output logic [15:0]      tx_ext_word,
  output logic [15:0]      tx_len_word,
  output logic [63:0]      tx_data,
  output logic             tx_abort,
  input  wire logic        tx_done,
  input  wire logic        tx_ok,
  input  wire logic        tx_lost,
  input  wire logic        tx_err,
  input  wire logic        rx_valid,
  input  wire logic [4:0]  rx_buf,
  input  wire logic [4:0]  rx_filter,
  input  wire logic [15:0] rx_id_word,
  input  wire logic [15:0] rx_ext_word,
  input  wire logic [15:0] rx_len_word,
  input  wire logic [63:0] rx_data,
  input  wire logic        rem_valid,
  input  wire logic [2:0]  rem_buf,
  output logic             irq
);

  typedef struct packed {
    logic [7:0][7:0]  ctl;
    logic [7:0]       abort_pend;
    cmb_pkg::cmb_tx_e state;
    logic [2:0]       cur;
    logic [4:0]       irq_st;
    logic [4:0]       irq_en;
    logic             irq;
    logic             aw_have;
    logic [11:0]      aw_addr;
    logic             w_have;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic [15:0]      tx_id;
    logic [15:0]      tx_ext;
    logic [15:0]      tx_len;
    logic [63:0]      tx_data;
    logic             tx_abort;
  } cmb_state_s;

  cmb_state_s q;
  cmb_state_s d;
  logic [15:0] mem [cmb_pkg::NUM_BUF][cmb_pkg::BUF_WORDS];

  function automatic logic [2:0] cmb_decode(input logic [11:0] a);
    if (a[11] && !a[10])                                    cmb_decode = cmb_pkg::DEC_BUF;
    else if (a[11:4] == cmb_pkg::OFS_CTL0[11:4])            cmb_decode = cmb_pkg::DEC_CTL;
    else if (a[11:2] == cmb_pkg::OFS_IRQ_ST[11:2])          cmb_decode = cmb_pkg::DEC_IRQ_ST;
    else if (a[11:2] == cmb_pkg::OFS_IRQ_EN[11:2])          cmb_decode = cmb_pkg::DEC_IRQ_EN;
    else if (a[11:2] == cmb_pkg::OFS_IRQ_CLR[11:2])         cmb_decode = cmb_pkg::DEC_IRQ_CLR;
    else if (a[11:2] == cmb_pkg::OFS_ENGINE[11:2])          cmb_decode = cmb_pkg::DEC_ENGINE;
    else                                                    cmb_decode = cmb_pkg::DEC_NONE;
  endfunction : cmb_decode

  function automatic logic [15:0] cmb_word_mask(input logic [2:0] w);
    case (w)
      cmb_pkg::W_SID:  cmb_word_mask = cmb_pkg::MASK_SID;
      cmb_pkg::W_EID:  cmb_word_mask = cmb_pkg::MASK_EID;
      cmb_pkg::W_LEN:  cmb_word_mask = cmb_pkg::MASK_LEN;
      cmb_pkg::W_STAT: cmb_word_mask = cmb_pkg::MASK_STAT;
      default:         cmb_word_mask = cmb_pkg::MASK_DATA;
    endcase
  endfunction : cmb_word_mask

  // Arbitration over pending transmit buffers
  logic       pend_any;
  logic [2:0] sel;
  always_comb begin
    logic [1:0] best;
    best     = 2'h0;
    pend_any = 1'b0;
    sel      = 3'h0;
    for (int i = 0; i < cmb_pkg::NUM_TX; i++) begin
      if (q.ctl[i][cmb_pkg::CTL_DIR] && q.ctl[i][cmb_pkg::CTL_REQ] && !q.abort_pend[i]) begin // R1
        if (!pend_any || q.ctl[i][1:0] >= best) begin // R8 R18
          best     = q.ctl[i][1:0];
          sel      = 3'(i);
          pend_any = 1'b1;
        end
      end
    end
  end

  logic        wr_go;
  logic [2:0]  wr_dec;
  logic [2:0]  rd_dec;
  logic        ctl_wr;
  logic        buf_wr;
  logic [15:0] wr_bmask;
  logic [15:0] wr_old;
  logic [15:0] wr_new;
  logic        rx_take;
  logic        launch;
  logic [4:0]  ev;

  assign wr_go    = q.aw_have && q.w_have && !q.bvalid;
  assign wr_dec   = cmb_decode(q.aw_addr);
  assign rd_dec   = cmb_decode(s_axi_araddr);
  assign ctl_wr   = wr_go && (wr_dec == cmb_pkg::DEC_CTL);
  assign buf_wr   = wr_go && (wr_dec == cmb_pkg::DEC_BUF);
  assign wr_bmask = {{8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
  assign wr_old   = mem[q.aw_addr[9:5]][q.aw_addr[4:2]];
  assign wr_new   = ((wr_old & ~wr_bmask) | (q.w_data[15:0] & wr_bmask))
                    & cmb_word_mask(q.aw_addr[4:2]);
  // Transmit buffers with direction set take no received frames
  assign rx_take  = rx_valid
                    && !(rx_buf < 5'(cmb_pkg::NUM_TX) && q.ctl[rx_buf[2:0]][cmb_pkg::CTL_DIR]);
  assign launch   = (q.state == cmb_pkg::CMB_TX_IDLE) && pend_any && !ctl_wr;

  always_comb begin
    logic [7:0] nb;
    logic [2:0] idx;
    nb  = 8'h00;
    idx = 3'h0;
    d   = q;
    ev  = 5'h00;

    // Write channel capture, either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    if (wr_go) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = (wr_dec == cmb_pkg::DEC_NONE) ? cmb_pkg::RESP_SLVERR : cmb_pkg::RESP_OKAY;
      if (wr_dec == cmb_pkg::DEC_IRQ_EN && q.w_strb[0])
        d.irq_en = q.w_data[4:0];
      if (wr_dec == cmb_pkg::DEC_IRQ_CLR && q.w_strb[0])
        d.irq_st = q.irq_st & ~q.w_data[4:0];
      if (ctl_wr) begin
        for (int b = 0; b < 2; b++) begin
          if (q.w_strb[b]) begin // R10
            idx = {q.aw_addr[3:2], 1'(b)};
            nb  = (q.w_data[8*b +: 8] & cmb_pkg::CTL_SW_MASK)
                  | (q.ctl[idx] & cmb_pkg::CTL_FLAGS);
            if (q.ctl[idx][cmb_pkg::CTL_REQ] && !nb[cmb_pkg::CTL_REQ]) begin // R6
              if (q.state == cmb_pkg::CMB_TX_BUSY && q.cur == idx) begin
                nb[cmb_pkg::CTL_REQ] = 1'b1;
                d.abort_pend[idx]    = 1'b1;
              end else begin
                nb[cmb_pkg::CTL_ABT] = 1'b1; // R2
                ev[cmb_pkg::EV_ABORT] = 1'b1;
              end
            end
            if (!q.ctl[idx][cmb_pkg::CTL_REQ] && nb[cmb_pkg::CTL_REQ]) // R5
              nb = nb & ~cmb_pkg::CTL_FLAGS; // R9
            d.ctl[idx] = nb;
          end
        end
      end
    end

    // Remote frame answered automatically
    if (rem_valid && d.ctl[rem_buf][cmb_pkg::CTL_DIR] && d.ctl[rem_buf][cmb_pkg::CTL_RTR]
        && !d.ctl[rem_buf][cmb_pkg::CTL_REQ]) begin // R7
      d.ctl[rem_buf][cmb_pkg::CTL_REQ] = 1'b1;
      d.ctl[rem_buf] = d.ctl[rem_buf] & ~cmb_pkg::CTL_FLAGS; // R9
    end

    // Transmit engine sequencing
    case (q.state)
      cmb_pkg::CMB_TX_IDLE: begin
        if (launch) begin // R18
          d.state   = cmb_pkg::CMB_TX_BUSY;
          d.cur     = sel;
          d.tx_id   = mem[sel][cmb_pkg::W_SID]; // R11 R12
          d.tx_ext  = mem[sel][cmb_pkg::W_EID]; // R13
          d.tx_len  = mem[sel][cmb_pkg::W_LEN]; // R15
          d.tx_data = {mem[sel][cmb_pkg::W_DATA0 + 3'h3], mem[sel][cmb_pkg::W_DATA0 + 3'h2],
                       mem[sel][cmb_pkg::W_DATA0 + 3'h1], mem[sel][cmb_pkg::W_DATA0]}; // R16
        end
      end
      cmb_pkg::CMB_TX_BUSY: begin
        if (tx_done) begin
          d.state             = cmb_pkg::CMB_TX_IDLE;
          d.abort_pend[q.cur] = 1'b0;
          if (tx_ok) begin
            d.ctl[q.cur][cmb_pkg::CTL_REQ] = 1'b0; // R5
            d.ctl[q.cur][cmb_pkg::CTL_ABT] = 1'b0; // R2
            ev[cmb_pkg::EV_TX_OK] = 1'b1;
          end else begin
            if (tx_lost) begin
              d.ctl[q.cur][cmb_pkg::CTL_LARB] = 1'b1; // R3
              ev[cmb_pkg::EV_LOST] = 1'b1;
            end
            if (tx_err) begin
              d.ctl[q.cur][cmb_pkg::CTL_ERR] = 1'b1; // R4
              ev[cmb_pkg::EV_ERR] = 1'b1;
            end
            if (q.abort_pend[q.cur] || !(tx_lost || tx_err)) begin
              d.ctl[q.cur][cmb_pkg::CTL_REQ] = 1'b0; // R6
              d.ctl[q.cur][cmb_pkg::CTL_ABT] = 1'b1; // R2
              ev[cmb_pkg::EV_ABORT] = 1'b1;
            end
          end
        end
      end
      default: d.state = cmb_pkg::CMB_TX_IDLE;
    endcase

    ev[cmb_pkg::EV_RX] = rx_take;
    // Events win over a clear in the same cycle
    d.irq_st = d.irq_st | ev;

    // Read channel
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp  = cmb_pkg::RESP_OKAY;
      d.rdata  = 32'h0000_0000;
      case (rd_dec)
        cmb_pkg::DEC_CTL:    d.rdata = {16'h0000, q.ctl[{s_axi_araddr[3:2], 1'b1}],
                                        q.ctl[{s_axi_araddr[3:2], 1'b0}]};
        cmb_pkg::DEC_IRQ_ST: d.rdata = {27'h0000000, q.irq_st};
        cmb_pkg::DEC_IRQ_EN: d.rdata = {27'h0000000, q.irq_en};
        cmb_pkg::DEC_ENGINE: d.rdata = {24'h000000, q.abort_pend[7:4], q.cur, q.state};
        cmb_pkg::DEC_BUF:    d.rdata = {16'h0000, mem[s_axi_araddr[9:5]][s_axi_araddr[4:2]]};
        cmb_pkg::DEC_IRQ_CLR: d.rdata = 32'h0000_0000;
        default:             d.rresp = cmb_pkg::RESP_SLVERR;
      endcase
    end

    d.awready = !d.aw_have && !d.bvalid;
    d.wready  = !d.w_have && !d.bvalid;
    d.arready = !d.rvalid;
    d.irq     = |(d.irq_st & d.irq_en);
    d.tx_abort = d.abort_pend[d.cur] && (d.state == cmb_pkg::CMB_TX_BUSY);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q         <= '0;
      q.ctl     <= {cmb_pkg::NUM_TX{cmb_pkg::CTL_RESET}};
      q.irq_st  <= cmb_pkg::IRQ_RESET;
      q.irq_en  <= cmb_pkg::IRQ_RESET;
      q.state   <= cmb_pkg::CMB_TX_IDLE;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Buffer RAM: a received frame takes priority over a software write
  always_ff @(posedge clk) begin
    if (buf_wr)
      mem[q.aw_addr[9:5]][q.aw_addr[4:2]] <= wr_new;
    if (rx_take) begin
      mem[rx_buf][cmb_pkg::W_SID] <= rx_id_word & cmb_pkg::MASK_SID; // R11
      mem[rx_buf][cmb_pkg::W_EID] <= rx_ext_word & cmb_pkg::MASK_EID; // R13
      mem[rx_buf][cmb_pkg::W_LEN] <= rx_len_word & cmb_pkg::MASK_LEN; // R15
      for (int w = 0; w < 4; w++)
        mem[rx_buf][cmb_pkg::W_DATA0 + 3'(w)] <= rx_data[16*w +: 16]; // R16
      mem[rx_buf][cmb_pkg::W_STAT] <= {3'h0, rx_filter, 8'h00}; // R17
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = q.rdata;
  assign tx_valid      = (q.state == cmb_pkg::CMB_TX_BUSY);
  assign tx_buf        = q.cur;
  assign tx_extended   = q.tx_id[cmb_pkg::SID_IDE]; // R12
  assign tx_id_word    = q.tx_id;
  assign tx_ext_word   = q.tx_ext;
  assign tx_len_word   = q.tx_len;
  assign tx_data       = q.tx_data;
  assign tx_abort      = q.tx_abort;
  assign irq           = q.irq;

  property p_launch_dir;
    @(posedge clk) disable iff (reset)
    launch |-> q.ctl[sel][cmb_pkg::CTL_DIR] ##1 tx_valid && tx_buf == $past(sel);
  endproperty
  a_launch_dir: assert property (p_launch_dir) else $error("launched non-transmit buffer"); // R1

  property p_abort_flag;
    @(posedge clk) disable iff (reset)
    tx_valid && tx_done && !tx_ok && tx_abort |=> q.ctl[$past(q.cur)][cmb_pkg::CTL_ABT]
      && !q.ctl[$past(q.cur)][cmb_pkg::CTL_REQ];
  endproperty
  a_abort_flag: assert property (p_abort_flag) else $error("abort not flagged"); // R2

  property p_lost;
    @(posedge clk) disable iff (reset)
    tx_valid && tx_done && !tx_ok && tx_lost |=> q.ctl[$past(q.cur)][cmb_pkg::CTL_LARB];
  endproperty
  a_lost: assert property (p_lost) else $error("lost arbitration not flagged"); // R3

  property p_err;
    @(posedge clk) disable iff (reset)
    tx_valid && tx_done && !tx_ok && tx_err |=> q.ctl[$past(q.cur)][cmb_pkg::CTL_ERR];
  endproperty
  a_err: assert property (p_err) else $error("bus error not flagged"); // R4

  property p_ok_clears;
    @(posedge clk) disable iff (reset)
    tx_valid && tx_done && tx_ok |=> !q.ctl[$past(q.cur)][cmb_pkg::CTL_REQ]
      && !q.ctl[$past(q.cur)][cmb_pkg::CTL_ABT] && !tx_valid;
  endproperty
  a_ok_clears: assert property (p_ok_clears) else $error("request kept after success"); // R5

  property p_remote;
    @(posedge clk) disable iff (reset)
    rem_valid && q.ctl[rem_buf][cmb_pkg::CTL_DIR] && q.ctl[rem_buf][cmb_pkg::CTL_RTR]
      |=> q.ctl[$past(rem_buf)][cmb_pkg::CTL_REQ];
  endproperty
  a_remote: assert property (p_remote) else $error("remote frame not answered"); // R7

  property p_req_clears_flags;
    @(posedge clk) disable iff (reset)
    $rose(q.ctl[0][cmb_pkg::CTL_REQ]) |-> (q.ctl[0] & cmb_pkg::CTL_FLAGS) == 8'h00;
  endproperty
  a_req_clears_flags: assert property (p_req_clears_flags) else $error("flags kept"); // R9

  property p_filter_hit;
    @(posedge clk) disable iff (reset)
    rx_take |=> mem[$past(rx_buf)][cmb_pkg::W_STAT] == {3'h0, $past(rx_filter), 8'h00};
  endproperty
  a_filter_hit: assert property (p_filter_hit) else $error("filter number not stored"); // R17

  property p_irq;
    @(posedge clk) disable iff (reset)
    (ev & q.irq_en) != 5'h00 && !wr_go |=> irq && (q.irq_st & $past(ev)) == $past(ev);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output wrong");

  c_launch: cover property (@(posedge clk) disable iff (reset) launch);
  c_tx_ok:  cover property (@(posedge clk) disable iff (reset) tx_valid && tx_done && tx_ok);
  c_abort:  cover property (@(posedge clk) disable iff (reset) tx_abort ##[1:20] tx_done);
  c_rx:     cover property (@(posedge clk) disable iff (reset) rx_take);

endmodule : cmb_buffer_ctrl

// File: cmb_engine_model.sv
// Protocol engine model: ends each transmit attempt after a set delay
`timescale 1ns/1ps
module cmb_engine_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       tx_valid,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] lat,
  output logic            tx_done,
  output logic            tx_ok,
  output logic            tx_lost,
  output logic            tx_err
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk) begin
    if (reset || !tx_valid || tx_done) begin
      cnt_q   <= 8'h00;
      tx_done <= 1'b0;
      tx_ok   <= 1'b0;
      tx_lost <= 1'b0;
      tx_err  <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      // Mode 3 ends the attempt with no qualifier, which counts as an abort
      if (cnt_q == lat) begin
        tx_done <= 1'b1;
        tx_ok   <= (mode == 2'h0);
        tx_lost <= (mode == 2'h1);
        tx_err  <= (mode == 2'h2);
      end
    end
  end
endmodule : cmb_engine_model

// File: cmb_buffer_ctrl_tb.sv
// Testbench for the CAN message buffer control block
`timescale 1ns/1ps
module cmb_buffer_ctrl_tb;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, mode;
  logic [15:0] rx_id_word, rx_ext_word, rx_len_word, tx_id_word, tx_ext_word, tx_len_word;
  logic [63:0] rx_data, tx_data;
  logic [4:0]  rx_buf, rx_filter;
  logic [2:0]  tx_buf, rem_buf;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  lat;
  logic        clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tx_valid;
  logic        tx_extended, tx_abort, tx_done, tx_ok, tx_lost, tx_err, rx_valid, rem_valid, irq;
  int          error_cnt, tests_run, k;
  logic [15:0] msk [8] = '{16'h1FFF, 16'h0FFF, 16'hFF1F, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
                           16'h1F00};
  logic [15:0] tw [7] = '{16'h1235, 16'h0ABC, 16'hFC08, 16'h2211, 16'h4433, 16'h6655, 16'h8877};
  logic [15:0] pw [3] = '{16'h8B89, 16'h8A8A, 16'h888A};
  logic [2:0]  fe [3] = '{3'h3, 3'h5, 3'h6};

  cmb_buffer_ctrl u_cmb_buffer_ctrl (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tx_valid, .tx_buf, .tx_extended, .tx_id_word, .tx_ext_word,
    .tx_len_word, .tx_data, .tx_abort, .tx_done, .tx_ok, .tx_lost, .tx_err, .rx_valid, .rx_buf,
    .rx_filter, .rx_id_word, .rx_ext_word, .rx_len_word, .rx_data, .rem_valid, .rem_buf, .irq);
  cmb_engine_model u_cmb_engine_model (.clk, .reset, .tx_valid, .mode, .lat, .tx_done, .tx_ok,
    .tx_lost, .tx_err);

  always #12.5 clk = ~clk;

  task automatic close_out();
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      error_cnt++;
    end
  endtask : chk

  task automatic give_up();
    chk("wait bound", 64'h1, 64'h0);
    close_out();
  endtask : give_up

  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    input logic [1:0] er = cmb_pkg::RESP_OKAY);
    int i;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (i == 200) give_up();
    s_axi_bready <= 1'b0;
    chk("bresp", 64'(er), 64'(s_axi_bresp));
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [15:0] e, input string nm,
                    input logic [1:0] er = cmb_pkg::RESP_OKAY);
    int i;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (i == 200) give_up();
    s_axi_rready <= 1'b0;
    chk(nm, 64'({er, 16'h0000, e}), 64'({s_axi_rresp, s_axi_rdata}));
  endtask : rd

  // Waits for a launch, or with dn set for the end of an attempt
  task automatic wt(input bit dn);
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if ((dn ? tx_done : tx_valid) === 1'b1) break;
    end
    if (i == 200) give_up();
  endtask : wt

  task automatic rx(input logic [4:0] b, input logic [4:0] f, input logic [15:0] id);
    @(posedge clk);
    rx_buf     <= b;
    rx_filter  <= f;
    rx_id_word <= id;
    rx_valid   <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
  endtask : rx

  task automatic rem(input logic [2:0] b);
    @(posedge clk);
    rem_buf   <= b;
    rem_valid <= 1'b1;
    @(posedge clk);
    rem_valid <= 1'b0;
  endtask : rem

  function automatic logic [11:0] ba(input int n, input int w);
    return cmb_pkg::OFS_BUF + 12'(n * 32 + w * 4);
  endfunction : ba

  initial begin
    {clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {rx_valid, rem_valid, rem_buf, rx_buf, rx_filter, rx_id_word, mode} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    reset       = 1'b1;
    s_axi_wstrb = 4'h3;
    lat         = 8'h03;
    rx_ext_word = 16'h0ABC;
    rx_len_word = 16'h0008;
    rx_data     = 64'h0000000000003412;
    error_cnt   = 0;
    tests_run   = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (k = 0; k < 4; k++) rd(cmb_pkg::OFS_CTL0 + 12'(4 * k), 16'h0000, "ctl reset");
    chk("irq reset", 64'h0, 64'(irq));
    wr(12'h400, 16'hFFFF, cmb_pkg::RESP_SLVERR);
    rd(12'h400, 16'h0000, "unmapped", cmb_pkg::RESP_SLVERR);
    for (k = 0; k < 8; k++) wr(ba(9, k), (k == 2) ? 16'hFEEF : 16'hFFFF);
    for (k = 0; k < 8; k++)
      rd(ba(9, k), msk[k] & ((k == 2) ? 16'hFEEF : 16'hFFFF), "bits");
    for (k = 0; k < 7; k++) wr(ba(0, k), tw[k]);
    wr(cmb_pkg::OFS_IRQ_EN, 16'h0001);
    wr(cmb_pkg::OFS_CTL0, 16'h008B);
    wt(0);
    chk("tx_buf", 64'h0, 64'(tx_buf));
    chk("frame", {1'b1, 16'h1235, 16'h0ABC, 16'hFC08},
        64'({tx_extended, tx_id_word, tx_ext_word, tx_len_word}));
    chk("tx_data", 64'h8877665544332211, tx_data);
    wt(1);
    rd(cmb_pkg::OFS_CTL0, 16'h0083, "ctl sent");
    chk("irq tx", 64'h1, 64'(irq));
    wr(cmb_pkg::OFS_IRQ_CLR, 16'h001F);
    @(posedge clk);
    chk("irq clr", 64'h0, 64'(irq));
    lat  <= 8'd40;
    mode <= 2'h1;
    wr(cmb_pkg::OFS_CTL0, 16'h0088);
    wt(1);
    rd(cmb_pkg::OFS_CTL0, 16'h00A8, "ctl lost");
    mode <= 2'h2;
    wt(1);
    rd(cmb_pkg::OFS_CTL0, 16'h00B8, "ctl err");
    wt(0);
    wr(cmb_pkg::OFS_CTL0, 16'h0080);
    chk("tx_abort", 64'h1, 64'(tx_abort));
    mode <= 2'h3;
    wt(1);
    rd(cmb_pkg::OFS_CTL0, 16'h00F0, "ctl abort");
    mode <= 2'h0;
    wr(cmb_pkg::OFS_CTL0, 16'h0088);
    rd(cmb_pkg::OFS_CTL0, 16'h0088, "ctl flags");
    wt(1);
    rd(cmb_pkg::OFS_CTL0, 16'h0080, "ctl ok");
    lat <= 8'h03;
    for (k = 0; k < 3; k++) begin
      wr(cmb_pkg::OFS_CTL0 + 12'(4 * k + 4), pw[k]);
      wt(0);
      chk("first", 64'(fe[k]), 64'(tx_buf));
      rd(cmb_pkg::OFS_ENGINE, 16'({fe[k], 1'b1}), "engine");
      wt(1);
      wt(0);
      chk("second", 64'(fe[k] ^ 3'h1), 64'(tx_buf));
      wt(1);
    end
    wr(cmb_pkg::OFS_CTL0, 16'h8080);
    rem(3'h1);
    rd(cmb_pkg::OFS_CTL0, 16'h8080, "no auto");
    wr(cmb_pkg::OFS_CTL0, 16'h8480);
    rem(3'h1);
    wt(0);
    chk("remote", 64'h1, 64'(tx_buf));
    wt(1);
    wr(cmb_pkg::OFS_IRQ_CLR, 16'h001F);
    wr(ba(0, 7), 16'h0000);
    rx(5'd0, 5'h03, 16'hFFFF);
    rd(ba(0, 7), 16'h0000, "tx stat");
    rx(5'd10, 5'h15, 16'hFFFF);
    rd(ba(10, 7), 16'h1500, "filter");
    rd(ba(10, 0), 16'h1FFF, "rx id");
    rd(ba(10, 1), 16'h0ABC, "rx ext");
    rd(ba(10, 3), 16'h3412, "rx data");
    rd(cmb_pkg::OFS_IRQ_ST, 16'h0010, "irq st");
    chk("irq masked", 64'h0, 64'(irq));
    wr(cmb_pkg::OFS_IRQ_EN, 16'h0010);
    @(posedge clk);
    chk("irq rx", 64'h1, 64'(irq));
    wr(cmb_pkg::OFS_IRQ_CLR, 16'h0010);
    @(posedge clk);
    chk("irq off", 64'h0, 64'(irq));
    close_out();
  end
endmodule : cmb_buffer_ctrl_tb
